// ===== hdl/rsso_core.sv
// Rotate, subtract-with-borrow and decrement-skip datapath of the core
`timescale 1ns/100ps
module rsso_core (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       START,
  input  wire logic [1:0] OPCODE,
  input  wire logic [7:0] ACC_IN,
  input  wire logic [7:0] MEM_IN,
  output logic      [7:0] ACC_OUT,
  output logic            ACC_WR,
  output logic      [7:0] MEM_OUT,
  output logic            MEM_WR,
  output logic            DONE,
  output logic            BUSY,
  output logic            SKIP,
  output logic            CARRY_FLAG,
  output logic            ZERO_FLAG,
  output logic            SIGNED_EXCESS_FLAG,
  output logic            HALF_CARRY_FLAG,
  output logic            SIGNED_BORROW_FLAG,
  output logic            CHAINED_NIL_FLAG
);
  import rsso_pkg::*;

  // ****************************************************************
  // Operand arithmetic
  // ****************************************************************
  rsso_state_t state;
  logic [1:0]  dummy_left;
  logic        take;
  logic [8:0]  diff_wide;
  logic [4:0]  diff_low;
  logic [7:0]  diff;
  logic        diff_excess;
  logic [7:0]  rotated;
  logic [7:0]  decremented;

  // A request is only taken between instructions; dummy cycles refuse it
  assign take = START && (state == RSSO_IDLE);

  // Borrow-in is the inverted carry, so carry means "no borrow"
  assign diff_wide = {1'b0, ACC_IN} - {1'b0, MEM_IN}
                     - {8'h00, ~CARRY_FLAG};
  assign diff_low  = {1'b0, ACC_IN[NIBBLE_MSB:0]}
                     - {1'b0, MEM_IN[NIBBLE_MSB:0]}
                     - {4'h0, ~CARRY_FLAG};
  assign diff      = diff_wide[DATA_MSB:0];
  // Overflow: operand signs differ and result sign leaves the minuend's
  assign diff_excess = (ACC_IN[DATA_MSB] != MEM_IN[DATA_MSB])
                     && (diff[DATA_MSB] != ACC_IN[DATA_MSB]);
  assign rotated     = {CARRY_FLAG, MEM_IN[DATA_MSB:1]};
  assign decremented = MEM_IN - DATA_ONE;

  // Skip decode shared by the sequencer and the BUSY/SKIP flops, so the
  // two can never disagree on whether a skip was taken
  function automatic logic is_taken_skip(input logic [1:0] op,
                                         input logic [7:0] dec);
    return (op == OP_DECREMENT_SKIP_IF_NIL_MEM)
           && (dec == DATA_ZERO);
  endfunction : is_taken_skip

  // ****************************************************************
  // Sequencer for the dummy cycles of a taken skip
  // ****************************************************************
  // Only the decrement-skip with a zero result leaves idle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state      <= RSSO_IDLE;
      dummy_left <= 2'h0;
    end else begin
      case (state)
        RSSO_IDLE: begin
          if (take && is_taken_skip(OPCODE, decremented)) begin
            state      <= RSSO_DUMMY;
            dummy_left <= SKIP_DUMMY_CYCLES;
          end
        end
        RSSO_DUMMY: begin
          if (dummy_left == 2'h1) begin
            state      <= RSSO_IDLE;
            dummy_left <= 2'h0;
          end else begin
            dummy_left <= dummy_left - 2'h1;
          end
        end
        default: begin
          state      <= RSSO_IDLE;
          dummy_left <= 2'h0;
        end
      endcase
    end
  end

  // Busy and skip stand through the dummy cycles; the fetch unit
  // discards the instruction fetched under SKIP
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      BUSY <= 1'b0;
      SKIP <= 1'b0;
    end else if (take && is_taken_skip(OPCODE, decremented)) begin
      BUSY <= 1'b1;
      SKIP <= 1'b1;
    end else if (state == RSSO_DUMMY && dummy_left == 2'h1) begin
      BUSY <= 1'b0;
      SKIP <= 1'b0;
    end
  end

  // ****************************************************************
  // Result write-back strobes
  // ****************************************************************
  // Results and strobes stand one cycle after the request is taken
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ACC_OUT <= DATA_RESET;
      ACC_WR  <= 1'b0;
      MEM_OUT <= DATA_RESET;
      MEM_WR  <= 1'b0;
      DONE    <= 1'b0;
    end else begin
      ACC_WR <= 1'b0;
      MEM_WR <= 1'b0;
      DONE   <= take;
      if (take) begin
        case (OPCODE)
          OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
            ACC_OUT <= rotated;
            ACC_WR  <= 1'b1;
          end
          OP_SUBTRACT_BORROW_TO_ACC: begin
            ACC_OUT <= diff;
            ACC_WR  <= 1'b1;
          end
          OP_SUBTRACT_BORROW_TO_MEM: begin
            MEM_OUT <= diff;
            MEM_WR  <= 1'b1;
          end
          default: begin
            MEM_OUT <= decremented;
            MEM_WR  <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Decrement-skip leaves every flag alone; rotate touches carry only
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CARRY_FLAG         <= FLAG_RESET;
      ZERO_FLAG          <= FLAG_RESET;
      SIGNED_EXCESS_FLAG <= FLAG_RESET;
      HALF_CARRY_FLAG    <= FLAG_RESET;
      SIGNED_BORROW_FLAG <= FLAG_RESET;
      CHAINED_NIL_FLAG   <= FLAG_RESET;
    end else if (take) begin
      case (OPCODE)
        OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
          CARRY_FLAG <= MEM_IN[0];
        end
        OP_SUBTRACT_BORROW_TO_ACC,
        OP_SUBTRACT_BORROW_TO_MEM: begin
          CARRY_FLAG         <= ~diff_wide[8];
          ZERO_FLAG          <= (diff == DATA_ZERO);
          SIGNED_EXCESS_FLAG <= diff_excess;
          HALF_CARRY_FLAG    <= ~diff_low[4];
          // Signed no-borrow: true sign of the difference inverted
          SIGNED_BORROW_FLAG <= ~(diff[DATA_MSB] ^ diff_excess);
          // Chained zero lets multi-byte compares keep a zero verdict
          CHAINED_NIL_FLAG   <= (diff == DATA_ZERO) && ZERO_FLAG;
        end
        default: begin
          CARRY_FLAG <= CARRY_FLAG;
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_rotate_result;
    take && OPCODE == OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC |=>
      ACC_WR && !MEM_WR
      && ACC_OUT == {$past(CARRY_FLAG), $past(MEM_IN[DATA_MSB:1])}
      && CARRY_FLAG == $past(MEM_IN[0]);
  endproperty
  a_rotate_result: assert property (p_rotate_result)
    else $error("rotate result or carry wrong");

  property p_rotate_flags;
    take && OPCODE == OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC |=>
      $stable(ZERO_FLAG) && $stable(SIGNED_EXCESS_FLAG)
      && $stable(HALF_CARRY_FLAG) && $stable(CHAINED_NIL_FLAG)
      && $stable(SIGNED_BORROW_FLAG);
  endproperty
  a_rotate_flags: assert property (p_rotate_flags)
    else $error("rotate changed a flag other than carry");

  property p_sub_acc;
    take && OPCODE == OP_SUBTRACT_BORROW_TO_ACC |=>
      ACC_WR && !MEM_WR && ACC_OUT == 8'($past(ACC_IN) - $past(MEM_IN)
      - {7'h00, ~$past(CARRY_FLAG)});
  endproperty
  a_sub_acc: assert property (p_sub_acc)
    else $error("accumulator subtract result wrong");

  property p_sub_mem;
    take && OPCODE == OP_SUBTRACT_BORROW_TO_MEM |=>
      MEM_WR && !ACC_WR && MEM_OUT == 8'($past(ACC_IN) - $past(MEM_IN)
      - {7'h00, ~$past(CARRY_FLAG)});
  endproperty
  a_sub_mem: assert property (p_sub_mem)
    else $error("memory subtract result wrong");

  property p_sub_carry;
    take && OPCODE[1] != OPCODE[0] |=>
      CARRY_FLAG == ({1'b0, $past(ACC_IN)} >=
                     {1'b0, $past(MEM_IN)} + {8'h00, ~$past(CARRY_FLAG)});
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract carry does not match sign of difference");

  property p_sub_zero;
    take && OPCODE[1] != OPCODE[0] |=>
      ZERO_FLAG == (8'($past(ACC_IN) - $past(MEM_IN)
                    - {7'h00, ~$past(CARRY_FLAG)}) == DATA_ZERO)
      && CHAINED_NIL_FLAG == (ZERO_FLAG && $past(ZERO_FLAG));
  endproperty
  a_sub_zero: assert property (p_sub_zero)
    else $error("subtract zero flag wrong");

  property p_dec_store;
    take && OPCODE == OP_DECREMENT_SKIP_IF_NIL_MEM |=>
      MEM_WR && !ACC_WR && MEM_OUT == 8'($past(MEM_IN) - 8'h01)
      && $stable(CARRY_FLAG) && $stable(ZERO_FLAG)
      && $stable(SIGNED_EXCESS_FLAG) && $stable(HALF_CARRY_FLAG)
      && $stable(SIGNED_BORROW_FLAG) && $stable(CHAINED_NIL_FLAG);
  endproperty
  a_dec_store: assert property (p_dec_store)
    else $error("decrement store or flag hold wrong");

  property p_skip_len;
    take && OPCODE == OP_DECREMENT_SKIP_IF_NIL_MEM && MEM_IN == 8'h01 |=>
      (SKIP && BUSY) [*2] ##1 !BUSY;
  endproperty
  a_skip_len: assert property (p_skip_len)
    else $error("taken skip does not span three cycles");

  property p_no_skip;
    take && OPCODE == OP_DECREMENT_SKIP_IF_NIL_MEM && MEM_IN != 8'h01 |=>
      !SKIP && !BUSY && DONE;
  endproperty
  a_no_skip: assert property (p_no_skip)
    else $error("nonzero decrement skipped");

  // A request made while BUSY stands is refused: no DONE and no write strobe follow
  property p_refuse_busy;
    START && BUSY |=> !DONE && !ACC_WR && !MEM_WR;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy)
    else $error("request taken during dummy cycles");

endmodule : rsso_core

// ===== shared/rsso_pkg.sv
// Constants and types shared by the rotate/subtract/skip datapath
package rsso_pkg;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  localparam logic [1:0] OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC = 2'h0;
  localparam logic [1:0] OP_SUBTRACT_BORROW_TO_ACC         = 2'h1;
  localparam logic [1:0] OP_SUBTRACT_BORROW_TO_MEM         = 2'h2;
  localparam logic [1:0] OP_DECREMENT_SKIP_IF_NIL_MEM      = 2'h3;

  // ****************************************************************
  // Data layout and reset values
  // ****************************************************************
  localparam int         DATA_MSB      = 7;
  localparam int         NIBBLE_MSB    = 3;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic       FLAG_RESET    = 1'b0;
  localparam logic [7:0] DATA_ZERO     = 8'h00;
  localparam logic [7:0] DATA_ONE      = 8'h01;

  // ****************************************************************
  // Timing: a taken skip lasts three instruction cycles, the first
  // being the execute cycle and the others dummy cycles
  // ****************************************************************
  localparam int         SKIP_TOTAL_CYCLES = 3;
  localparam logic [1:0] SKIP_DUMMY_CYCLES = 2'(SKIP_TOTAL_CYCLES - 1);

  // Sequencer states
  typedef enum logic [1:0] {
    RSSO_IDLE,
    RSSO_DUMMY
  } rsso_state_t;

endpackage : rsso_pkg

// ===== test/tb_rsso_core.sv
// Self-checking bench for the rotate, subtract and decrement-skip datapath
`timescale 1ns/100ps
module tb_rsso_core;
  import rsso_pkg::*;

  `define CHK(nm, exp, got) \
    begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
      end \
    end

  typedef struct packed {
    logic [1:0] wr;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [5:0] flg;
    logic       skip;
  } rsso_note_t;

  logic       CLK, RESETN, START;
  logic [1:0] OPCODE;
  logic [7:0] ACC_IN, MEM_IN, ACC_OUT, MEM_OUT;
  logic       ACC_WR, MEM_WR, DONE, BUSY, SKIP;
  logic       cf, zf, ovf, hcf, sbf, cnf;
  logic [5:0] flags;
  int         error_cnt    = 0;
  int         total_checks = 0;
  rsso_note_t notes[$];
  rsso_note_t mon_n;
  logic [7:0] m_acc = 8'h00;
  logic [7:0] m_mem = 8'h00;
  logic [5:0] m_f   = 6'h00;  // Carry, zero, excess, half, signed, chain
  logic [17:0] tbl [9] = '{{2'h0, 8'h00, 8'h01}, {2'h1, 8'h05, 8'h05},
                           {2'h2, 8'h05, 8'h05}, {2'h1, 8'h00, 8'h01},
                           {2'h2, 8'h80, 8'h01}, {2'h0, 8'h00, 8'hFE},
                           {2'h3, 8'h00, 8'h01}, {2'h3, 8'h00, 8'h00},
                           {2'h3, 8'h00, 8'h02}};

  assign flags = {cf, zf, ovf, hcf, sbf, cnf};

  rsso_core u_rsso_core (
    .CLK(CLK), .RESETN(RESETN), .START(START), .OPCODE(OPCODE),
    .ACC_IN(ACC_IN), .MEM_IN(MEM_IN), .ACC_OUT(ACC_OUT), .ACC_WR(ACC_WR),
    .MEM_OUT(MEM_OUT), .MEM_WR(MEM_WR), .DONE(DONE), .BUSY(BUSY),
    .SKIP(SKIP), .CARRY_FLAG(cf), .ZERO_FLAG(zf), .SIGNED_EXCESS_FLAG(ovf),
    .HALF_CARRY_FLAG(hcf), .SIGNED_BORROW_FLAG(sbf), .CHAINED_NIL_FLAG(cnf)
  );

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // ****************************************************************
  // Driver: issues one request and notes what must come back
  // ****************************************************************
  task automatic op(input logic [1:0] o, input logic [7:0] a,
                    input logic [7:0] m);
    logic [8:0] d;
    logic [4:0] h;
    logic       ex;
    rsso_note_t n;
    START  = 1'b1;
    OPCODE = o;
    ACC_IN = a;
    MEM_IN = m;
    n.wr   = 2'h1;
    n.skip = 1'b0;
    case (o)
      OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
        m_acc  = {m_f[5], m[7:1]};
        m_f[5] = m[0];
        n.wr   = 2'h2;
      end
      OP_DECREMENT_SKIP_IF_NIL_MEM: begin
        m_mem  = m - 8'h01;
        n.skip = (m_mem == 8'h00);
      end
      default: begin
        // Borrow seen as the ninth bit; same for the low nibble
        d  = {1'b0, a} - {1'b0, m} - {8'h00, ~m_f[5]};
        h  = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~m_f[5]};
        ex = (a[7] ^ m[7]) & (a[7] ^ d[7]);
        m_f = {~d[8], d[7:0] == 8'h00, ex, ~h[4], ~(d[7] ^ ex),
               (d[7:0] == 8'h00) & m_f[4]};
        if (o == OP_SUBTRACT_BORROW_TO_ACC) begin
          m_acc = d[7:0];
          n.wr  = 2'h2;
        end else begin
          m_mem = d[7:0];
        end
      end
    endcase
    n.acc = m_acc;
    n.mem = m_mem;
    n.flg = m_f;
    notes.push_back(n);
    @(posedge CLK);
    #1;
    if (n.skip) begin
      // A request held through the dummy cycles must be ignored
      `CHK("busy skip", 2'h3, {BUSY, SKIP})
      OPCODE = 2'($urandom);
      MEM_IN = 8'($urandom);
      @(posedge CLK);
      #1;
      `CHK("busy skip", 2'h3, {BUSY, SKIP})
      @(posedge CLK);
      #1;
      `CHK("busy skip", 2'h0, {BUSY, SKIP})
    end
  endtask : op

  // Final report and end of run
  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Monitor: each DONE consumes the oldest note
  // ****************************************************************
  always @(posedge CLK) begin
    #2;
    if (RESETN === 1'b1 && DONE !== 1'b0) begin
      if (notes.size() == 0) begin
        `CHK("spurious done", 1'b0, DONE)
      end else begin
        mon_n = notes.pop_front();
        `CHK("strobes", mon_n.wr, {ACC_WR, MEM_WR})
        `CHK("acc out", mon_n.acc, ACC_OUT)
        `CHK("mem out", mon_n.mem, MEM_OUT)
        `CHK("flags", mon_n.flg, flags)
        `CHK("skip", {2{mon_n.skip}}, {BUSY, SKIP})
      end
    end
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    #600000;
    error_cnt++;
    finish_test();
  end

  // Main sequence: reset, directed corners, then random mix
  initial begin
    void'($urandom(32'h3D98CC73));
    RESETN = 1'b0;
    START  = 1'b0;
    OPCODE = 2'h0;
    ACC_IN = 8'h00;
    MEM_IN = 8'h00;
    repeat (3) @(posedge CLK);
    #1;
    `CHK("reset data", 16'h0000, {ACC_OUT, MEM_OUT})
    `CHK("reset strobes", 5'h00, {ACC_WR, MEM_WR, DONE, BUSY, SKIP})
    `CHK("reset flags", 6'h00, flags)
    RESETN = 1'b1;
    @(posedge CLK);
    #1;
    foreach (tbl[i]) begin
      op(tbl[i][17:16], tbl[i][15:8], tbl[i][7:0]);
    end
    // Back to back random requests; small memory values make skips common
    repeat (400) begin
      op(2'($urandom), 8'($urandom),
         ($urandom % 4 == 0) ? 8'($urandom % 3) : 8'($urandom));
    end
    START = 1'b0;
    repeat (4) @(posedge CLK);
    `CHK("notes left", 0, notes.size())
    finish_test();
  end

endmodule : tb_rsso_core
